// ---- arsc_pkg.sv ----
// Package: constants and carriers for the recalibrate/security command handler
package arsc_pkg;

  // Command opcodes
  localparam logic [3:0] OP_RECAL_NIB     = 4'h1;
  localparam logic [7:0] OP_SEC_DISABLE   = 8'hF6;
  localparam logic [7:0] OP_ERASE_PREP    = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT    = 8'hF4;
  localparam logic [7:0] OP_FORMAT_UNIT   = 8'hF7;

  // Error register bit positions
  localparam int ERR_ABT_BIT = 2;
  localparam int ERR_TON_BIT = 1;
  // Status register bit positions
  localparam int ST_BSY_BIT  = 7;
  localparam int ST_RDY_BIT  = 6;
  localparam int ST_DSC_BIT  = 4;
  localparam int ST_DRQ_BIT  = 3;
  localparam int ST_ERR_BIT  = 0;

  // Values after reset
  localparam logic [7:0] ERR_RESET  = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h50;

  // Password sector layout, in 16-bit words
  localparam logic [7:0] PW_CTRL_WORD  = 8'h00;
  localparam logic [7:0] PW_FIRST_WORD = 8'h01;
  localparam logic [7:0] PW_LAST_WORD  = 8'h10;
  localparam logic [7:0] SECTOR_LAST   = 8'hFF;
  localparam int         PW_WORDS      = 16;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] mid;
    logic [7:0] hi;
  } arsc_lba_t;

  typedef struct packed {
    logic        seek_done;
    logic        seek_ok;
  } arsc_seek_t;

endpackage

// ---- arsc_pwcmp.sv ----
// Password capture and comparison against the selected stored password
`timescale 1ns/100ps
module arsc_pwcmp
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Sector word stream
  input  wire logic         start,
  input  wire logic         word_vld,
  input  wire logic [7:0]   word_idx,
  input  wire logic [15:0]  word,
  // Stored passwords
  input  wire logic [255:0] user_pw,
  input  wire logic [255:0] master_pw,
  // Result
  output logic              use_master,
  output logic              match
);

  localparam int PW_W = arsc_pkg::PW_WORDS;
  logic [PW_W-1:0] mism_q;
  logic            sel_q;

  // Identifier bit 0 of the control word selects the target
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sel_q <= 1'b0;
    else if (start)
      sel_q <= 1'b0;
    else if (word_vld && word_idx == arsc_pkg::PW_CTRL_WORD)
      sel_q <= word[0];
  end

  // Per-word compare; words past the password are ignored
  genvar g;
  generate
    for (g = 0; g < PW_W; g++)
    begin : g_word
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mism_q[g] <= 1'b1;
        else if (start)
          mism_q[g] <= 1'b1;
        else if (word_vld && word_idx == 8'(g + 1))
          mism_q[g] <= word != (sel_q ? master_pw[g*16 +: 16] : user_pw[g*16 +: 16]);
      end
    end
  endgenerate

  assign use_master = sel_q;
  assign match      = ~|mism_q;

endmodule

// ---- arsc_top.sv ----
// Top: recalibrate, security disable password and erase prepare command handler
// Functional notes
// - After an unrecoverable extended-address error, LBA low/mid/high show bits 7-0/15-8/23-16 or 31-24/39-32/47-40 per HOB.
// - Any opcode 1xh is recalibrate and seeks the heads to cylinder 0.
// - A failed recalibrate seek sets track-zero-not-found in error and the error bit in status.
// - Opcode F6h asks the host for exactly one 512-byte sector through the data port.
// - The received password is compared with the stored one and a match clears the lock.
// - Disabling the lock leaves the stored master password untouched.
// - Word 0 holds the identifier, words 1-16 the password, words 17-255 are ignored.
// - Identifier 0 selects the user password and 1 the master password.
// - Erase prepare completes with no data phase and no data request.
// - Erase unit without erase prepare just before it is aborted.
`timescale 1ns/100ps
module arsc_top
(
  // Clock and reset
  input  wire logic         MCLK,
  input  wire logic         RSTN,
  // Command register write
  input  wire logic         CMD_WR,
  input  wire logic [7:0]   CMD,
  input  wire logic         HOB,
  // Data port, host to device
  input  wire logic         DATA_WR,
  input  wire logic [15:0]  DATA_IN,
  // Servo seek interface
  input  wire logic         SEEK_DONE,
  input  wire logic         SEEK_OK,
  // Media error reporting
  input  wire logic         UNC_ERR,
  input  wire logic [47:0]  UNC_LBA,
  // Stored passwords and lock state
  input  wire logic [255:0] USER_PW,
  input  wire logic [255:0] MASTER_PW,
  input  wire logic         LOCK_SET,
  // Register outputs
  output logic [7:0]        ERROR_REG,
  output logic [7:0]        STATUS_REG,
  output logic [7:0]        LBA_LO,
  output logic [7:0]        LBA_MID,
  output logic [7:0]        LBA_HI,
  // Device actions
  output logic              SEEK_REQ,
  output logic              LOCK_EN,
  output logic              ERASE_GO,
  output logic              FORMAT_GO,
  output logic              ERASE_ARMED
);

  typedef enum logic [2:0] {S_IDLE, S_SEEK, S_PWXFER, S_PWCHK, S_DONE} arsc_state_t;

  arsc_state_t     st_q;
  logic [7:0]      widx_q;
  logic [47:0]     fail_lba_q;
  logic            abort_q;
  logic            ton_q;
  logic            pw_start;
  logic            pw_match;
  logic            pw_master;
  arsc_pkg::arsc_lba_t lba_view;

  wire is_recal = CMD[7:4] == arsc_pkg::OP_RECAL_NIB;

  arsc_pwcmp u_pwcmp
  (
    .clk        (MCLK),
    .rst_n      (RSTN),
    .start      (pw_start),
    .word_vld   (DATA_WR && st_q == S_PWXFER),
    .word_idx   (widx_q),
    .word       (DATA_IN),
    .user_pw    (USER_PW),
    .master_pw  (MASTER_PW),
    .use_master (pw_master),
    .match      (pw_match)
  );

  assign pw_start = CMD_WR && st_q == S_IDLE && CMD == arsc_pkg::OP_SEC_DISABLE;

  // Command sequencing
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q      <= S_IDLE;
      abort_q   <= 1'b0;
      ton_q     <= 1'b0;
      SEEK_REQ  <= 1'b0;
      ERASE_GO  <= 1'b0;
      FORMAT_GO <= 1'b0;
    end
    else
    begin
      SEEK_REQ  <= 1'b0;
      ERASE_GO  <= 1'b0;
      FORMAT_GO <= 1'b0;
      case (st_q)
        S_IDLE:
          if (CMD_WR)
          begin
            abort_q <= 1'b0;
            ton_q   <= 1'b0;
            if (is_recal)
            begin
              SEEK_REQ <= 1'b1;
              st_q     <= S_SEEK;
            end
            else if (CMD == arsc_pkg::OP_SEC_DISABLE)
              st_q <= S_PWXFER;
            else if (CMD == arsc_pkg::OP_ERASE_PREP)
              st_q <= S_DONE;
            else if (CMD == arsc_pkg::OP_ERASE_UNIT)
            begin
              abort_q  <= !ERASE_ARMED;
              ERASE_GO <= ERASE_ARMED;
              st_q     <= S_DONE;
            end
            else if (CMD == arsc_pkg::OP_FORMAT_UNIT)
            begin
              FORMAT_GO <= ERASE_ARMED;
              st_q      <= S_DONE;
            end
            else
              st_q <= S_DONE;
          end
        S_SEEK:
          if (SEEK_DONE)
          begin
            ton_q <= !SEEK_OK;
            st_q  <= S_DONE;
          end
        S_PWXFER:
          if (DATA_WR && widx_q == arsc_pkg::SECTOR_LAST)
            st_q <= S_PWCHK;
        S_PWCHK:
        begin
          abort_q <= !pw_match;
          st_q    <= S_DONE;
        end
        S_DONE:
          st_q <= S_IDLE;
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // Sector word counter: exactly 256 words per password block
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      widx_q <= arsc_pkg::PW_CTRL_WORD;
    else if (pw_start)
      widx_q <= arsc_pkg::PW_CTRL_WORD;
    else if (DATA_WR && st_q == S_PWXFER)
      widx_q <= widx_q + 8'h01;
  end

  // Erase-prepare arming; erase unit and format consume it
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      ERASE_ARMED <= 1'b0;
    else if (CMD_WR && st_q == S_IDLE)
      ERASE_ARMED <= CMD == arsc_pkg::OP_ERASE_PREP;
  end

  // Lock state; the master password is an input and is never written here
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      LOCK_EN <= 1'b0;
    else if (st_q == S_PWCHK && pw_match)
      LOCK_EN <= 1'b0;
    else if (ERASE_GO)
      LOCK_EN <= 1'b0;
    else if (LOCK_SET)
      LOCK_EN <= 1'b1;
  end

  // Error and status registers
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ERROR_REG  <= arsc_pkg::ERR_RESET;
      STATUS_REG <= arsc_pkg::STAT_RESET;
    end
    else
    begin
      ERROR_REG <= 8'h00;
      ERROR_REG[arsc_pkg::ERR_ABT_BIT] <= abort_q;
      ERROR_REG[arsc_pkg::ERR_TON_BIT] <= ton_q;
      STATUS_REG <= 8'h00;
      // Busy from the last word on, so status never reads idle before the compare ends
      STATUS_REG[arsc_pkg::ST_BSY_BIT] <= st_q == S_SEEK || st_q == S_PWCHK ||
                                           (st_q == S_PWXFER && DATA_WR && widx_q == arsc_pkg::SECTOR_LAST);
      STATUS_REG[arsc_pkg::ST_RDY_BIT] <= 1'b1;
      STATUS_REG[arsc_pkg::ST_DSC_BIT] <= st_q != S_SEEK;
      STATUS_REG[arsc_pkg::ST_DRQ_BIT] <= st_q == S_PWXFER && !(DATA_WR && widx_q == arsc_pkg::SECTOR_LAST);
      STATUS_REG[arsc_pkg::ST_ERR_BIT] <= abort_q || ton_q || UNC_ERR;
    end
  end

  // Failing LBA capture and HOB-selected view
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      fail_lba_q <= 48'h0000_0000_0000;
    else if (UNC_ERR)
      fail_lba_q <= UNC_LBA;
  end

  always_comb
  begin
    if (HOB)
      lba_view = {fail_lba_q[31:24], fail_lba_q[39:32], fail_lba_q[47:40]};
    else
      lba_view = {fail_lba_q[7:0], fail_lba_q[15:8], fail_lba_q[23:16]};
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LBA_LO  <= 8'h00;
      LBA_MID <= 8'h00;
      LBA_HI  <= 8'h00;
    end
    else
    begin
      LBA_LO  <= lba_view.lo;
      LBA_MID <= lba_view.mid;
      LBA_HI  <= lba_view.hi;
    end
  end

endmodule

// ---- arsc_top_monitor.sv ----
// Checker for the recalibrate and security command handler ports
`timescale 1ns/100ps
module arsc_top_monitor
(
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RSTN,
  // Host and servo side
  input wire logic        CMD_WR,
  input wire logic [7:0]  CMD,
  input wire logic        HOB,
  input wire logic        SEEK_DONE,
  input wire logic        SEEK_OK,
  input wire logic        UNC_ERR,
  input wire logic [47:0] UNC_LBA,
  // Device outputs
  input wire logic [7:0]  ERROR_REG,
  input wire logic [7:0]  STATUS_REG,
  input wire logic [7:0]  LBA_LO,
  input wire logic [7:0]  LBA_MID,
  input wire logic [7:0]  LBA_HI,
  input wire logic        SEEK_REQ,
  input wire logic        LOCK_EN,
  input wire logic        ERASE_ARMED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire         go = CMD_WR && !STATUS_REG[7] && !STATUS_REG[3];
  logic [47:0] cap_q;
  logic        seen_q;
  // Own copy of the failing address, so a capture slip shows up
  always_ff @(posedge MCLK or negedge RSTN)
    if (!RSTN)
    begin
      cap_q  <= '0;
      seen_q <= 1'b0;
    end
    else if (UNC_ERR)
    begin
      cap_q  <= UNC_LBA;
      seen_q <= 1'b1;
    end
  recal_seek_a: assert property (go && CMD[7:4] == 4'h1 |=> SEEK_REQ)
    else $error("recal seek");
  drq_start_a: assert property (go && CMD == 8'hF6 |-> ##2 STATUS_REG[3])
    else $error("disable drq");
  prep_nodrq_a: assert property (go && CMD == 8'hF3 |=> !STATUS_REG[3] [*4])
    else $error("prepare drq");
  track_zero_a: assert property (SEEK_DONE && !SEEK_OK |-> ##[1:3] ERROR_REG[1] && STATUS_REG[0])
    else $error("ton");
  lba_view_a: assert property (seen_q && $stable(HOB) && !UNC_ERR && !$past(UNC_ERR) && !$past(UNC_ERR, 2)
    |-> {LBA_LO, LBA_MID, LBA_HI} == (HOB ? {cap_q[31:24], cap_q[39:32], cap_q[47:40]}
    : {cap_q[7:0], cap_q[15:8], cap_q[23:16]})) else $error("lba");
  abort_lock_a: assert property ($rose(ERROR_REG[2]) |-> STATUS_REG[0] && LOCK_EN == $past(LOCK_EN, 2))
    else $error("abort lock");
  unarmed_a: assert property (go && CMD == 8'hF4 && !ERASE_ARMED |-> ##[1:4] ERROR_REG[2])
    else $error("unarmed erase");
  disarm_a: assert property (go && CMD != 8'hF3 && CMD != 8'hF4 && CMD != 8'hF7 |-> ##[1:3] !ERASE_ARMED)
    else $error("disarm");
endmodule

bind arsc_top arsc_top_monitor u_mon (.MCLK, .RSTN, .CMD_WR, .CMD, .HOB, .SEEK_DONE, .SEEK_OK, .UNC_ERR,
  .UNC_LBA, .ERROR_REG, .STATUS_REG, .LBA_LO, .LBA_MID, .LBA_HI, .SEEK_REQ, .LOCK_EN, .ERASE_ARMED);

// ---- arsc_host_model.sv ----
// Host controller model: command writes and password sector
`timescale 1ns/100ps
module arsc_host_model
(
  // Clock and status
  input  wire logic       clk,
  input  wire logic [7:0] status,
  // Task-file writes
  output logic            cmd_wr = 1'b0,
  output logic [7:0]      cmd = 8'h00,
  output logic            data_wr = 1'b0,
  output logic [15:0]     data_in = 16'h0000
);
  task automatic settle();
    for (int n = 0; n < 2000 && status[7:3] !== 5'b0_1010; n++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  task automatic issue(input logic [7:0] op);
    settle();
    cmd    = op;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Reserved words carry junk so the device must ignore them
  task automatic sector(input logic id, input logic [255:0] pw, input logic [15:0] fill);
    for (int n = 0; n < 50 && status[3] !== 1'b1; n++)
      @(negedge clk);
    for (int i = 0; i < 256; i++)
    begin
      data_wr = 1'b1;
      data_in = i == 0 ? {fill[15:1], id} : i <= 16 ? pw[(i - 1) * 16 +: 16] : fill ^ 16'(i);
      @(negedge clk);
    end
    data_wr = 1'b0;
  endtask
endmodule

// ---- arsc_top_tb_top.sv ----
// Testbench for the recalibrate and security command handler
`timescale 1ns/100ps
module arsc_top_tb_top;
  logic         MCLK = 0, RSTN = 0, HOB = 0, SEEK_DONE = 0, SEEK_OK = 0, UNC_ERR = 0, LOCK_SET = 0;
  logic         CMD_WR, DATA_WR, SEEK_REQ, LOCK_EN, ERASE_GO, FORMAT_GO, ERASE_ARMED;
  logic         ok_sel = 0, eg = 0, fg = 0;
  logic [7:0]   CMD, ERROR_REG, STATUS_REG, LBA_LO, LBA_MID, LBA_HI;
  logic [15:0]  DATA_IN;
  logic [47:0]  UNC_LBA = '0;
  logic [255:0] USER_PW, MASTER_PW;
  int           seed = 68882, fail_count = 0, n_compared = 0, cyc = 0, seeks = 0;
  arsc_top u_dut (.MCLK, .RSTN, .CMD_WR, .CMD, .HOB, .DATA_WR, .DATA_IN, .SEEK_DONE, .SEEK_OK, .UNC_ERR,
    .UNC_LBA, .USER_PW, .MASTER_PW, .LOCK_SET, .ERROR_REG, .STATUS_REG, .LBA_LO, .LBA_MID, .LBA_HI,
    .SEEK_REQ, .LOCK_EN, .ERASE_GO, .FORMAT_GO, .ERASE_ARMED);
  arsc_host_model u_host (.clk(MCLK), .status(STATUS_REG), .cmd_wr(CMD_WR), .cmd(CMD), .data_wr(DATA_WR),
    .data_in(DATA_IN));
  function automatic logic [23:0] lba_exp(input logic h, input logic [47:0] a);
    return h ? {a[31:24], a[39:32], a[47:40]} : {a[7:0], a[15:8], a[23:16]};
  endfunction
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
    forever #20 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    cyc++;
    eg <= eg | (ERASE_GO === 1'b1);
    fg <= fg | (FORMAT_GO === 1'b1);
    if (cyc == 6000)
    begin
      fail_count++;
      conclude();
    end
  end
  // Servo answers each seek a few cycles later
  always @(posedge MCLK)
    if (SEEK_REQ === 1'b1)
    begin
      seeks++;
      repeat (3) @(negedge MCLK);
      SEEK_OK   <= ok_sel;
      SEEK_DONE <= 1'b1;
      @(negedge MCLK);
      SEEK_DONE <= 1'b0;
    end
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      USER_PW[i * 32 +: 32]   = $random(seed);
      MASTER_PW[i * 32 +: 32] = $random(seed);
    end
    repeat (6) @(negedge MCLK);
    RSTN = 1;
    check("rst", {ERROR_REG, STATUS_REG}, {arsc_pkg::ERR_RESET, arsc_pkg::STAT_RESET});
    for (int i = 0; i < 16; i++)
    begin
      ok_sel = $random(seed);
      u_host.issue({4'h1, 4'(i)});
      u_host.settle();
      check("ton", {ERROR_REG[1], STATUS_REG[0]}, {2{~ok_sel}});
    end
    check("seeks", seeks, 16);
    for (int c = 0; c < 4; c++)
    begin
      LOCK_SET = 1;
      @(negedge MCLK);
      LOCK_SET = 0;
      check("locked", LOCK_EN, 1);
      u_host.issue(arsc_pkg::OP_SEC_DISABLE);
      u_host.sector(c[0], c[0] ^ c[1] ? MASTER_PW : USER_PW, 16'($random(seed)));
      u_host.settle();
      check("lock", LOCK_EN, c[1]);
      check("abort", {ERROR_REG[2], STATUS_REG[0]}, {2{c[1]}});
    end
    for (int k = 0; k < 4; k++)
    begin
      eg = 0;
      fg = 0;
      if (k < 3)
      begin
        u_host.issue(arsc_pkg::OP_ERASE_PREP);
        check("armed", ERASE_ARMED, 1);
      end
      if (k == 2)
      begin
        u_host.issue(8'hE0);
        check("disarm", ERASE_ARMED, 0);
      end
      u_host.issue(k == 1 ? arsc_pkg::OP_FORMAT_UNIT : arsc_pkg::OP_ERASE_UNIT);
      u_host.settle();
      check("go", {eg, fg, ERROR_REG[2]}, k == 0 ? 3'b100 : k == 1 ? 3'b010 : 3'b001);
    end
    UNC_LBA[31:0]  = $random(seed);
    UNC_LBA[47:32] = 16'($random(seed));
    UNC_ERR = 1;
    @(negedge MCLK);
    UNC_ERR = 0;
    for (int h = 0; h < 2; h++)
    begin
      HOB = h[0];
      repeat (2) @(negedge MCLK);
      check("lba", {LBA_LO, LBA_MID, LBA_HI}, lba_exp(h[0], UNC_LBA));
    end
    conclude();
  end
endmodule
